// ===== rtl/pin_mux_pkg.sv
// shared constants for the three-port pin function multiplexer
package pin_mux_pkg;
  // interface mode field codes
  localparam logic [1:0] MODE_PORT = 2'h0;
  localparam logic [1:0] MODE_RSVD = 2'h1;
  localparam logic [1:0] MODE_WAVE = 2'h2;
  localparam logic [1:0] MODE_FIFO = 2'h3;
  // register offsets (plain port bus)
  localparam logic [3:0] ADDR_IFMODE = 4'h0;
  localparam logic [3:0] ADDR_A_ALT = 4'h1;
  localparam logic [3:0] ADDR_C_ALT = 4'h2;
  localparam logic [3:0] ADDR_POLAR = 4'h3;
  localparam logic [3:0] ADDR_WAKE = 4'h4;
  localparam logic [3:0] ADDR_IRQCFG = 4'h5;
  localparam logic [3:0] ADDR_A_OUT = 4'h6;
  localparam logic [3:0] ADDR_A_OE = 4'h7;
  localparam logic [3:0] ADDR_B_OUT = 4'h8;
  localparam logic [3:0] ADDR_B_OE = 4'h9;
  localparam logic [3:0] ADDR_C_OUT = 4'hA;
  localparam logic [3:0] ADDR_C_OE = 4'hB;
  localparam logic [3:0] ADDR_A_IN = 4'hC;
  localparam logic [3:0] ADDR_B_IN = 4'hD;
  localparam logic [3:0] ADDR_C_IN = 4'hE;
  localparam logic [3:0] ADDR_STATUS = 4'hF;
  // bit positions
  localparam int BIT_IRQ0 = 0;
  localparam int BIT_IRQ1 = 1;
  localparam int BIT_OE_IN = 2;
  localparam int BIT_WAKE_PIN = 3;
  localparam int BIT_SEL0 = 4;
  localparam int BIT_SEL1 = 5;
  localparam int BIT_COMMIT = 6;
  localparam int BIT_CS_FLAG = 7;
  localparam int POL_OE = 4;
  localparam int POL_COMMIT = 5;
  localparam int WAKE_EN = 1;
  localparam int WAKE_POL = 4;
  localparam int WAKE_PIN_SEL = 7;
  localparam int IRQ0_TYPE = 0;
  localparam int IRQ1_TYPE = 1;
  // status / interrupt bit positions
  localparam int ST_IRQ0 = 0;
  localparam int ST_IRQ1 = 1;
  localparam int ST_WAKE = 2;
  localparam int ST_W = 3;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
endpackage : pin_mux_pkg

// ===== rtl/port_abc_pin_function_mux.sv
// pin function multiplexer for ports a, b and c
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module port_abc_pin_function_mux
  import pin_mux_pkg::*;
#(
  parameter int WIDTH = 8
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic irq,
  // port a pins
  input wire logic [WIDTH-1:0] port_a_bit_in,
  output logic [WIDTH-1:0] port_a_bit_out,
  output logic [WIDTH-1:0] port_a_bit_oe,
  // port b pins
  input wire logic [WIDTH-1:0] port_b_bit_in,
  output logic [WIDTH-1:0] port_b_bit_out,
  output logic [WIDTH-1:0] port_b_bit_oe,
  // port c pins
  input wire logic [WIDTH-1:0] port_c_bit_in,
  output logic [WIDTH-1:0] port_c_bit_out,
  output logic [WIDTH-1:0] port_c_bit_oe,
  // internal function side
  input wire logic [WIDTH-1:0] waveform_address_out,
  input wire logic [WIDTH-1:0] fifo_data_low_byte_out,
  input wire logic fifo_data_drive,
  output logic [WIDTH-1:0] fifo_data_low_byte_in,
  input wire logic fifo_status_flag_four,
  output logic ext_irq_zero,
  output logic ext_irq_one,
  output logic fifo_output_enable_in,
  output logic [1:0] fifo_select,
  output logic packet_commit_in,
  output logic fifo_chip_select,
  // suspend and wakeup
  input wire logic suspend_req,
  output logic suspended,
  output logic osc_restart
);
  import pin_mux_pkg::*;

  // the register file and pin maps are one byte wide
  if (WIDTH != 8)
  begin : g_bad_width
    $error("port width must be 8");
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [1:0] interface_mode_config_reg, interface_mode_config_next;
  logic [7:0] port_a_alt_function_select_reg, port_a_alt_next;
  logic [7:0] port_c_alt_function_select_reg, port_c_alt_next;
  logic [7:0] fifo_pin_polarity_reg, polar_next;
  logic [7:0] wake_cfg_reg, wake_next;
  logic [7:0] irq_cfg_reg, irq_cfg_next;
  logic [7:0] a_out_reg, a_out_next, a_oe_reg, a_oe_next;
  logic [7:0] b_out_reg, b_out_next, b_oe_reg, b_oe_next;
  logic [7:0] c_out_reg, c_out_next, c_oe_reg, c_oe_next;
  logic [ST_W-1:0] status_reg, status_next, mask_reg, mask_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [ST_W-1:0] events;
  logic wake_asserted;

  always_comb
  begin
    interface_mode_config_next = interface_mode_config_reg;
    port_a_alt_next = port_a_alt_function_select_reg;
    port_c_alt_next = port_c_alt_function_select_reg;
    polar_next = fifo_pin_polarity_reg;
    wake_next = wake_cfg_reg;
    irq_cfg_next = irq_cfg_reg;
    a_out_next = a_out_reg;
    a_oe_next = a_oe_reg;
    b_out_next = b_out_reg;
    b_oe_next = b_oe_reg;
    c_out_next = c_out_reg;
    c_oe_next = c_oe_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    rdata_next = ZERO8;
    if (reg_write)
    begin
      unique case (reg_addr)
        ADDR_IFMODE: interface_mode_config_next = reg_wdata[1:0];
        ADDR_A_ALT: port_a_alt_next = reg_wdata;
        ADDR_C_ALT: port_c_alt_next = reg_wdata;
        ADDR_POLAR: polar_next = reg_wdata;
        ADDR_WAKE: wake_next = reg_wdata;
        ADDR_IRQCFG:
        begin
          irq_cfg_next = {ZERO8[7:2], reg_wdata[1:0]};
          mask_next = reg_wdata[ST_W+1:2];
        end
        ADDR_A_OUT: a_out_next = reg_wdata;
        ADDR_A_OE: a_oe_next = reg_wdata;
        ADDR_B_OUT: b_out_next = reg_wdata;
        ADDR_B_OE: b_oe_next = reg_wdata;
        ADDR_C_OUT: c_out_next = reg_wdata;
        ADDR_C_OE: c_oe_next = reg_wdata;
        ADDR_STATUS: status_next = status_reg & ~reg_wdata[ST_W-1:0];
        default: ;
      endcase
    end
    // set wins over write-one-to-clear
    status_next = status_next | events;
    if (reg_read)
    begin
      unique case (reg_addr)
        ADDR_IFMODE: rdata_next = {6'h00, interface_mode_config_reg};
        ADDR_A_ALT: rdata_next = port_a_alt_function_select_reg;
        ADDR_C_ALT: rdata_next = port_c_alt_function_select_reg;
        ADDR_POLAR: rdata_next = fifo_pin_polarity_reg;
        ADDR_WAKE: rdata_next = wake_cfg_reg;
        ADDR_IRQCFG: rdata_next = {3'h0, mask_reg, irq_cfg_reg[1:0]};
        ADDR_A_OUT: rdata_next = a_out_reg;
        ADDR_A_OE: rdata_next = a_oe_reg;
        ADDR_B_OUT: rdata_next = b_out_reg;
        ADDR_B_OE: rdata_next = b_oe_reg;
        ADDR_C_OUT: rdata_next = c_out_reg;
        ADDR_C_OE: rdata_next = c_oe_reg;
        ADDR_A_IN: rdata_next = port_a_bit_in;
        ADDR_B_IN: rdata_next = port_b_bit_in;
        ADDR_C_IN: rdata_next = port_c_bit_in;
        ADDR_STATUS: rdata_next = {suspended, 4'h0, status_reg};
        default: rdata_next = ZERO8;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      interface_mode_config_reg <= MODE_PORT;
      port_a_alt_function_select_reg <= ZERO8;
      port_c_alt_function_select_reg <= ZERO8;
      fifo_pin_polarity_reg <= ZERO8;
      wake_cfg_reg <= ZERO8;
      irq_cfg_reg <= ZERO8;
      a_out_reg <= ZERO8;
      a_oe_reg <= ZERO8;
      b_out_reg <= ZERO8;
      b_oe_reg <= ZERO8;
      c_out_reg <= ZERO8;
      c_oe_reg <= ZERO8;
      status_reg <= '0;
      mask_reg <= MASK_RESET[ST_W-1:0];
      rdata_reg <= ZERO8;
    end
    else
    begin
      interface_mode_config_reg <= interface_mode_config_next;
      port_a_alt_function_select_reg <= port_a_alt_next;
      port_c_alt_function_select_reg <= port_c_alt_next;
      fifo_pin_polarity_reg <= polar_next;
      wake_cfg_reg <= wake_next;
      irq_cfg_reg <= irq_cfg_next;
      a_out_reg <= a_out_next;
      a_oe_reg <= a_oe_next;
      b_out_reg <= b_out_next;
      b_oe_reg <= b_oe_next;
      c_out_reg <= c_out_next;
      c_oe_reg <= c_oe_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq = |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // pin function selection
  // ----------------------------------------------------------------
  logic fifo_mode, bus_mode, wake_sel;
  assign fifo_mode = (interface_mode_config_reg == MODE_FIFO);
  assign bus_mode = fifo_mode || (interface_mode_config_reg == MODE_WAVE);
  // pin 3 is the wakeup input when enabled, selected and not driven
  assign wake_sel = wake_cfg_reg[WAKE_EN] && wake_cfg_reg[WAKE_PIN_SEL]
    && !a_oe_reg[BIT_WAKE_PIN];

  logic [7:0] a_alt_in;
  always_comb
  begin
    a_alt_in = ZERO8;
    a_alt_in[BIT_IRQ0] = port_a_alt_function_select_reg[BIT_IRQ0];
    a_alt_in[BIT_IRQ1] = port_a_alt_function_select_reg[BIT_IRQ1];
    a_alt_in[BIT_OE_IN] = fifo_mode;
    a_alt_in[BIT_WAKE_PIN] = wake_sel;
    a_alt_in[BIT_SEL0] = fifo_mode;
    a_alt_in[BIT_SEL1] = fifo_mode;
    a_alt_in[BIT_COMMIT] = fifo_mode;
    a_alt_in[BIT_CS_FLAG] = fifo_mode;
  end

  // flag out outside fifo mode when cfg bit 7 set; chip select in fifo mode
  logic flag_out;
  assign flag_out = !fifo_mode
    && port_a_alt_function_select_reg[BIT_CS_FLAG];

  always_comb
  begin
    port_a_bit_out = a_out_reg;
    port_a_bit_oe = a_oe_reg & ~a_alt_in;
    port_a_bit_out[BIT_CS_FLAG] = flag_out ? fifo_status_flag_four
      : a_out_reg[BIT_CS_FLAG];
    port_a_bit_oe[BIT_CS_FLAG] = flag_out | (a_oe_reg[BIT_CS_FLAG]
      & ~a_alt_in[BIT_CS_FLAG]);
  end

  // port b: data low byte in bus modes
  assign port_b_bit_out = bus_mode ? fifo_data_low_byte_out
    : b_out_reg;
  assign port_b_bit_oe = bus_mode ? {WIDTH{fifo_data_drive}} : b_oe_reg;
  assign fifo_data_low_byte_in = bus_mode ? port_b_bit_in : ZERO8;

  // port c: per-bit address outputs
  assign port_c_bit_out = (port_c_alt_function_select_reg
    & waveform_address_out)
    | (~port_c_alt_function_select_reg & c_out_reg);
  assign port_c_bit_oe = port_c_alt_function_select_reg | c_oe_reg;

  // slave fifo controls; output enable and commit gated by chip select, select by fifo mode only
  logic cs_active;
  assign cs_active = fifo_mode && !port_a_bit_in[BIT_CS_FLAG];
  assign fifo_chip_select = cs_active;
  assign fifo_output_enable_in = cs_active && (port_a_bit_in[BIT_OE_IN]
    == fifo_pin_polarity_reg[POL_OE]);
  assign packet_commit_in = cs_active && (port_a_bit_in[BIT_COMMIT]
    == fifo_pin_polarity_reg[POL_COMMIT]);
  assign fifo_select = fifo_mode ?
    {port_a_bit_in[BIT_SEL1], port_a_bit_in[BIT_SEL0]} : 2'h0;

  // ----------------------------------------------------------------
  // external interrupts and wakeup
  // ----------------------------------------------------------------
  logic irq0_low, irq1_low, irq0_prev_reg, irq1_prev_reg;
  logic wake_prev_reg, susp_reg, susp_next, wake_edge;
  assign irq0_low = port_a_alt_function_select_reg[BIT_IRQ0]
    && !port_a_bit_in[BIT_IRQ0];
  assign irq1_low = port_a_alt_function_select_reg[BIT_IRQ1]
    && !port_a_bit_in[BIT_IRQ1];
  // edge on falling entry into low, level while low
  assign ext_irq_zero = irq_cfg_reg[IRQ0_TYPE] ? (irq0_low && !irq0_prev_reg)
    : irq0_low;
  assign ext_irq_one = irq_cfg_reg[IRQ1_TYPE] ? (irq1_low && !irq1_prev_reg)
    : irq1_low;
  assign wake_asserted = wake_sel
    && (port_a_bit_in[BIT_WAKE_PIN] == wake_cfg_reg[WAKE_POL]);
  assign wake_edge = wake_sel && susp_reg
    && (port_a_bit_in[BIT_WAKE_PIN] != wake_prev_reg);
  assign events = {wake_edge, ext_irq_one, ext_irq_zero};

  always_comb
  begin
    susp_next = susp_reg;
    if (wake_edge)
      susp_next = 1'b0;
    else if (suspend_req && !wake_asserted)
      susp_next = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      irq0_prev_reg <= 1'b0;
      irq1_prev_reg <= 1'b0;
      wake_prev_reg <= 1'b0;
      susp_reg <= 1'b0;
    end
    else
    begin
      irq0_prev_reg <= irq0_low;
      irq1_prev_reg <= irq1_low;
      wake_prev_reg <= port_a_bit_in[BIT_WAKE_PIN];
      susp_reg <= susp_next;
    end
  end

  assign suspended = susp_reg;
  assign osc_restart = wake_edge;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_mode_reset;
    @(posedge ref_clk) !reset_n |=> interface_mode_config_reg == MODE_PORT
      && port_a_bit_oe == ZERO8 && port_c_bit_oe == ZERO8;
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("pins not inputs after reset");
  property p_irq0_edge;
    @(posedge ref_clk) disable iff (!reset_n)
      (irq_cfg_reg[IRQ0_TYPE] && ext_irq_zero) |=> !ext_irq_zero;
  endproperty
  a_irq0_edge: assert property (p_irq0_edge)
    else $error("edge irq held longer than one cycle");
  property p_c_addr;
    @(posedge ref_clk) disable iff (!reset_n)
      port_c_alt_function_select_reg[0] |->
      port_c_bit_out[0] == waveform_address_out[0] && port_c_bit_oe[0];
  endproperty
  a_c_addr: assert property (p_c_addr)
    else $error("port c bit 0 not address");
  property p_b_bus;
    @(posedge ref_clk) disable iff (!reset_n)
      !bus_mode |-> port_b_bit_oe == b_oe_reg;
  endproperty
  a_b_bus: assert property (p_b_bus)
    else $error("port b not gpio outside bus modes");
  property p_no_suspend;
    @(posedge ref_clk) disable iff (!reset_n)
      (!susp_reg && wake_asserted) |=> !susp_reg;
  endproperty
  a_no_suspend: assert property (p_no_suspend)
    else $error("suspended while wakeup asserted");
  property p_wake_exit;
    @(posedge ref_clk) disable iff (!reset_n)
      wake_edge |=> !susp_reg && status_reg[ST_WAKE];
  endproperty
  a_wake_exit: assert property (p_wake_exit)
    else $error("wakeup did not leave suspend");
  property p_fifo_in_only;
    @(posedge ref_clk) disable iff (!reset_n)
      fifo_mode |-> !port_a_bit_oe[BIT_OE_IN] && !port_a_bit_oe[BIT_COMMIT];
  endproperty
  a_fifo_in_only: assert property (p_fifo_in_only)
    else $error("fifo input pin driven");
  property p_cs_gate;
    @(posedge ref_clk) disable iff (!reset_n)
      port_a_bit_in[BIT_CS_FLAG] |-> !fifo_output_enable_in
      && !packet_commit_in;
  endproperty
  a_cs_gate: assert property (p_cs_gate)
    else $error("strobe passed without chip select");
  property p_irq0_sel;
    @(posedge ref_clk) disable iff (!reset_n)
      !port_a_alt_function_select_reg[BIT_IRQ0] |-> !ext_irq_zero;
  endproperty
  a_irq0_sel: assert property (p_irq0_sel)
    else $error("irq0 active while pin is gpio");
endmodule : port_abc_pin_function_mux

`default_nettype wire

// ===== tb/host_model.sv
// far-side parallel host: drives its pins and resolves each shared wire
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input wire logic ref_clk,
  // device pin drivers
  input wire logic [7:0] dev_out,
  input wire logic [7:0] dev_oe,
  // host drive commands
  input wire logic [7:0] host_val,
  input wire logic [7:0] host_en,
  // resolved wire levels
  output logic [7:0] level
);
  logic [7:0] last_reg;
  // ----------------------------------------
  // wire resolution
  // ----------------------------------------
  // host drives fifo select, commit, output enable and chip select
  // as plain levels
  // an undriven wire shows the inverse of its last level, never a hold
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (dev_oe[i])
        level[i] = dev_out[i];
      else if (host_en[i])
        level[i] = host_val[i];
      else
        level[i] = ~last_reg[i];
    end
  end
  always_ff @(posedge ref_clk)
  begin
    last_reg <= level;
  end
endmodule : host_model
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the port a/b/c pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pin_mux_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic irq;
  logic [7:0] a_in, a_out, a_oe, b_in, b_out, b_oe, c_in, c_out, c_oe;
  logic [7:0] a_val = 8'hFF, a_en = 8'hFF, b_val = 8'h00, b_en = 8'hFF;
  logic [7:0] wave_addr = 8'h00, fd_out = 8'h00, fd_in, v;
  logic fd_drive = 1'b0, flag4 = 1'b0, suspend_req = 1'b0;
  logic irq0, irq1, oe_in, commit, cs, suspended, osc_restart;
  logic [1:0] fsel;
  logic restart_seen = 1'b0;
  int num_errors = 0;
  int num_checks = 0;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (osc_restart === 1'b1) restart_seen <= 1'b1;
  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  port_abc_pin_function_mux i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .port_a_bit_in(a_in), .port_a_bit_out(a_out), .port_a_bit_oe(a_oe),
    .port_b_bit_in(b_in), .port_b_bit_out(b_out), .port_b_bit_oe(b_oe),
    .port_c_bit_in(c_in), .port_c_bit_out(c_out), .port_c_bit_oe(c_oe),
    .waveform_address_out(wave_addr), .fifo_data_low_byte_out(fd_out),
    .fifo_data_drive(fd_drive), .fifo_data_low_byte_in(fd_in),
    .fifo_status_flag_four(flag4), .ext_irq_zero(irq0), .ext_irq_one(irq1),
    .fifo_output_enable_in(oe_in), .fifo_select(fsel),
    .packet_commit_in(commit), .fifo_chip_select(cs),
    .suspend_req(suspend_req), .suspended(suspended),
    .osc_restart(osc_restart));
  host_model i_host_a (.ref_clk(ref_clk), .dev_out(a_out), .dev_oe(a_oe),
    .host_val(a_val), .host_en(a_en), .level(a_in));
  host_model i_host_b (.ref_clk(ref_clk), .dev_out(b_out), .dev_oe(b_oe),
    .host_val(b_val), .host_en(b_en), .level(b_in));
  host_model i_host_c (.ref_clk(ref_clk), .dev_out(c_out), .dev_oe(c_oe),
    .host_val(8'h3C), .host_en(8'hFF), .level(c_in));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] seen,
                     input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", n, exp, seen);
      num_errors++;
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle
  task automatic results;
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial
  begin
    #200000;
    num_errors++;
    results();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    chk("oe a", a_oe, 8'h00);
    chk("oe b", b_oe, 8'h00);
    chk("oe c", c_oe, 8'h00);
    rd(ADDR_IFMODE, v);
    chk("mode", {6'h00, v[1:0]}, {6'h00, MODE_PORT});
    // gpio both ways
    wr(ADDR_A_OUT, 8'hA5);
    wr(ADDR_A_OE, 8'hFF);
    chk("a out", a_out, 8'hA5);
    chk("a oe", a_oe, 8'hFF);
    rd(ADDR_A_IN, v);
    chk("a in drv", v, 8'hA5);
    wr(ADDR_A_OE, 8'h00);
    a_val <= 8'h3C;
    rd(ADDR_A_IN, v);
    chk("a in", v, 8'h3C);
    a_val <= 8'hFF;
    // level irq on pin 0, edge irq on pin 1
    wr(ADDR_A_ALT, 8'h03);
    wr(ADDR_IRQCFG, 8'h06);
    a_val <= 8'hFE;
    idle(3);
    chk("irq0 lvl", {7'h00, irq0}, 8'h01);
    chk("irq", {7'h00, irq}, 8'h01);
    a_val <= 8'hFF;
    idle(2);
    chk("irq0 off", {7'h00, irq0}, 8'h00);
    wr(ADDR_STATUS, 8'h07);
    chk("irq clr", {7'h00, irq}, 8'h00);
    wr(ADDR_IRQCFG, 8'h0A);
    a_val <= 8'hFD;
    idle(4);
    chk("irq1 edge", {7'h00, irq1}, 8'h00);
    rd(ADDR_STATUS, v);
    chk("st irq1", {7'h00, v[1]}, 8'h01);
    a_val <= 8'hFF;
    wr(ADDR_STATUS, 8'h07);
    wr(ADDR_A_ALT, 8'h00);
    // fifo mode: enable, select, commit, chip select
    wr(ADDR_IFMODE, {6'h00, MODE_FIFO});
    a_val <= 8'b0010_1011;
    idle(1);
    chk("oe low", {7'h00, oe_in}, 8'h01);
    chk("sel", {6'h00, fsel}, 8'h02);
    chk("commit", {7'h00, commit}, 8'h01);
    chk("cs", {7'h00, cs}, 8'h01);
    wr(ADDR_POLAR, 8'h30);
    chk("oe pol", {7'h00, oe_in}, 8'h00);
    chk("commit pol", {7'h00, commit}, 8'h00);
    wr(ADDR_POLAR, 8'h00);
    a_val <= 8'b1010_1011;
    idle(1);
    chk("cs gate", {6'h00, oe_in, commit}, 8'h00);
    // fifo data byte on port b
    fd_out <= 8'h5A;
    fd_drive <= 1'b1;
    idle(1);
    chk("fd oe", b_oe, 8'hFF);
    chk("fd out", b_out, 8'h5A);
    fd_drive <= 1'b0;
    b_val <= 8'hC3;
    idle(1);
    chk("fd in", fd_in, 8'hC3);
    wr(ADDR_IFMODE, {6'h00, MODE_WAVE});
    chk("wave fd", fd_in, 8'hC3);
    wr(ADDR_IFMODE, {6'h00, MODE_PORT});
    chk("port fd", fd_in, 8'h00);
    wr(ADDR_IFMODE, {6'h00, MODE_RSVD});
    chk("rsvd fd", fd_in, 8'h00);
    wr(ADDR_IFMODE, {6'h00, MODE_PORT});
    wr(ADDR_B_OE, 8'h0F);
    chk("b gpio", b_oe, 8'h0F);
    // flag output on pin 7, address on port c
    flag4 <= 1'b1;
    wr(ADDR_A_ALT, 8'h80);
    chk("flag oe", {7'h00, a_oe[7]}, 8'h01);
    chk("flag", {7'h00, a_out[7]}, 8'h01);
    wave_addr <= 8'h96;
    wr(ADDR_C_ALT, 8'h0F);
    chk("c oe", c_oe, 8'h0F);
    chk("c out", {4'h0, c_out[3:0]}, 8'h06);
    rd(ADDR_C_IN, v);
    chk("c in", {v[7:4], 4'h0}, 8'h30);
    // second wakeup: blocks suspend, then wakes it
    wr(ADDR_WAKE, 8'h92);
    a_val <= 8'hFF;
    suspend_req <= 1'b1;
    idle(5);
    chk("no susp", {7'h00, suspended}, 8'h00);
    a_val <= 8'hF7;
    idle(5);
    chk("susp", {7'h00, suspended}, 8'h01);
    a_val <= 8'hFF;
    suspend_req <= 1'b0;
    idle(5);
    chk("restart", {7'h00, restart_seen}, 8'h01);
    rd(ADDR_STATUS, v);
    chk("st wake", {7'h00, v[2]}, 8'h01);
    results();
  end
endmodule : tb
`default_nettype wire
